// file: design/spbl_boot_latch.sv
// strap pin boot latch with axi4-lite register slave
//
// Overview of operation
// RL1 - capture every strap level when a power-on, watchdog or brownout reset is released
// RL2 - captured straps stay unchanged until the next system reset is released, whatever the pins do later
// RL3 - software reads all five captured strap bits from a status register
// RL4 - weak internal pulls are enabled on every strap pin while reset is held
// RL5 - after reset release, strap pins return to their ordinary function
// RL6 - ldo strap 0 selects 3.3 V flash supply, 1 selects 1.8 V
// RL7 - boot select 1 gives spi boot; both straps 0 give download boot
// RL8 - log strap 1 enables boot log on console tx; 0 keeps it silent
// RL9 - log and edge straps pick sdio sample and output edges
// RL10 - firmware bits may override regulator voltage and sdio timing after boot
// RL11 - outside party holds power-up enable low at least 50 us to reset
// RL12 - status register has fixed bit order; writes to it are ignored
`include "spbl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module spbl_boot_latch (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // system reset sources, level high while the reset is asserted, except power-up enable which is low
    input wire logic por_rst_in,
    input wire logic rtc_wdt_rst_in,
    input wire logic brownout_rst_in,
    input wire logic power_up_enable_input,
    // strap pins
    input wire logic ldo_voltage_strap,
    input wire logic boot_select_strap,
    input wire logic download_qualifier_strap,
    input wire logic log_and_timing_strap,
    input wire logic sdio_edge_strap,
    // pad control
    output logic strap_pull_en,
    output logic [4:0] strap_pull_up,
    output logic strap_func_en,
    // boot configuration
    output logic flash_ldo_1v8,
    output logic boot_download,
    output logic boot_log_en,
    output logic sdio_sample_rise,
    output logic sdio_output_rise,
    output logic boot_console_tx_silent,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // pin synchronisers, first stage read only by second
    logic [8:0] pin_s1_r;
    logic [8:0] pin_s2_r;
    wire [8:0] pin_raw = {power_up_enable_input, brownout_rst_in, rtc_wdt_rst_in,
        por_rst_in, sdio_edge_strap, log_and_timing_strap, download_qualifier_strap,
        boot_select_strap, ldo_voltage_strap};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_s1_r <= 9'h000;
            pin_s2_r <= 9'h000;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    wire [4:0] strap_sync = pin_s2_r[4:0];
    // power-up enable low counts as a chip reset
    wire sys_rst_req = pin_s2_r[5] | pin_s2_r[6] | pin_s2_r[7] | ~pin_s2_r[8];

    // state and capture
    spbl_pkg::spbl_state_t state_r;
    spbl_pkg::spbl_state_t state_nxt;
    logic [4:0] strap_r;
    logic [4:0] strap_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            spbl_pkg::SPBL_ST_RESET: begin
                if (!sys_rst_req) begin
                    state_nxt = spbl_pkg::SPBL_ST_CAPTURE;
                end
            end
            spbl_pkg::SPBL_ST_CAPTURE: begin
                state_nxt = spbl_pkg::SPBL_ST_HELD;
            end
            spbl_pkg::SPBL_ST_HELD: begin
                if (sys_rst_req) begin
                    state_nxt = spbl_pkg::SPBL_ST_RESET;
                end
            end
            default: begin
                state_nxt = spbl_pkg::SPBL_ST_RESET;
            end
        endcase
    end

    // sample only on the release edge of the system reset
    wire capture_now = (state_r == spbl_pkg::SPBL_ST_RESET) && !sys_rst_req; // see RL1
    assign strap_nxt = capture_now ? strap_sync : strap_r; // see RL2

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= spbl_pkg::SPBL_ST_RESET;
            strap_r <= `SPBL_PULL_DEFAULT;
        end else begin
            state_r <= state_nxt;
            strap_r <= strap_nxt;
        end
    end

    // pad control
    wire in_reset = (state_nxt == spbl_pkg::SPBL_ST_RESET) || capture_now;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_pull_en <= 1'b1;
            strap_pull_up <= `SPBL_PULL_DEFAULT;
            strap_func_en <= 1'b0;
        end else begin
            strap_pull_en <= in_reset; // see RL4
            strap_pull_up <= `SPBL_PULL_DEFAULT; // see RL4
            strap_func_en <= !in_reset; // see RL5
        end
    end

    // firmware override control
    logic [4:0] ovr_r;
    logic [4:0] ovr_nxt;

    wire ldo_eff = ovr_r[`SPBL_OVR_LDO_EN] ? ovr_r[`SPBL_OVR_LDO_VAL]
        : strap_r[`SPBL_BIT_LDO]; // see RL6 RL10
    wire samp_eff = ovr_r[`SPBL_OVR_SDIO_EN] ? ovr_r[`SPBL_OVR_SDIO_SAMP]
        : strap_r[`SPBL_BIT_LOG_TIM]; // see RL9 RL10
    wire out_eff = ovr_r[`SPBL_OVR_SDIO_EN] ? ovr_r[`SPBL_OVR_SDIO_OUT]
        : strap_r[`SPBL_BIT_SDIO_EDGE]; // see RL9 RL10
    wire dl_eff = !strap_r[`SPBL_BIT_BOOT_SEL] && !strap_r[`SPBL_BIT_DL_QUAL]; // see RL7
    wire log_eff = strap_r[`SPBL_BIT_LOG_TIM]; // see RL8
    wire booting = (state_r != spbl_pkg::SPBL_ST_HELD);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flash_ldo_1v8 <= 1'b0;
            boot_download <= 1'b0;
            boot_log_en <= 1'b1;
            sdio_sample_rise <= 1'b1;
            sdio_output_rise <= 1'b1;
            boot_console_tx_silent <= 1'b0;
        end else begin
            flash_ldo_1v8 <= ldo_eff;
            boot_download <= dl_eff;
            boot_log_en <= log_eff;
            sdio_sample_rise <= samp_eff;
            sdio_output_rise <= out_eff;
            boot_console_tx_silent <= !log_eff;
        end
    end

    // write channel: address and data taken in either order
    logic aw_held_r;
    logic w_held_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_r || aw_take;
    wire w_have = w_held_r || w_take;
    wire wr_go = aw_have && w_have && !s_axi_bvalid;
    wire [3:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    wire wr_ovr = (wr_addr == `SPBL_ADDR_OVR_CTRL);
    wire wr_ro = (wr_addr == `SPBL_ADDR_STRAP) || (wr_addr == `SPBL_ADDR_EFFECT)
        || (wr_addr == `SPBL_ADDR_SYS_STAT); // see RL12
    // overrides accepted only once boot has completed
    assign ovr_nxt = (wr_go && wr_ovr && wr_strb[0] && !booting)
        ? wr_data[4:0] : ovr_r; // see RL10

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SPBL_RESP_OKAY;
            ovr_r <= `SPBL_OVR_RESET;
        end else begin
            ovr_r <= ovr_nxt;
            aw_held_r <= aw_have && !wr_go;
            w_held_r <= w_have && !wr_go;
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            s_axi_awready <= !aw_have && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have && !s_axi_wready && !s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ovr || wr_ro) ? `SPBL_RESP_OKAY : `SPBL_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] rd_strap = {27'h0, strap_r}; // see RL3 RL12
    wire [31:0] rd_ovr = {27'h0, ovr_r};
    wire [31:0] rd_eff = {26'h0, boot_console_tx_silent, sdio_output_rise,
        sdio_sample_rise, boot_log_en, boot_download, flash_ldo_1v8};
    wire [31:0] rd_stat = {29'h0, strap_func_en, strap_pull_en, !booting};
    wire rd_hit = (s_axi_araddr == `SPBL_ADDR_STRAP) || (s_axi_araddr == `SPBL_ADDR_OVR_CTRL)
        || (s_axi_araddr == `SPBL_ADDR_EFFECT) || (s_axi_araddr == `SPBL_ADDR_SYS_STAT);
    wire [31:0] rd_mux = (s_axi_araddr == `SPBL_ADDR_STRAP) ? rd_strap
        : (s_axi_araddr == `SPBL_ADDR_OVR_CTRL) ? rd_ovr
        : (s_axi_araddr == `SPBL_ADDR_EFFECT) ? rd_eff
        : (s_axi_araddr == `SPBL_ADDR_SYS_STAT) ? rd_stat : 32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SPBL_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `SPBL_RESP_OKAY : `SPBL_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : spbl_boot_latch
`default_nettype wire

// file: design/spbl_consts.svh
// constants for the strap pin boot latch
`ifndef SPBL_CONSTS_SVH
`define SPBL_CONSTS_SVH
`define SPBL_ADDR_STRAP 4'h0
`define SPBL_ADDR_OVR_CTRL 4'h4
`define SPBL_ADDR_EFFECT 4'h8
`define SPBL_ADDR_SYS_STAT 4'hc
`define SPBL_BIT_LDO 0
`define SPBL_BIT_BOOT_SEL 1
`define SPBL_BIT_DL_QUAL 2
`define SPBL_BIT_LOG_TIM 3
`define SPBL_BIT_SDIO_EDGE 4
`define SPBL_OVR_LDO_EN 0
`define SPBL_OVR_LDO_VAL 1
`define SPBL_OVR_SDIO_EN 2
`define SPBL_OVR_SDIO_SAMP 3
`define SPBL_OVR_SDIO_OUT 4
`define SPBL_PULL_DEFAULT 5'h1a
`define SPBL_OVR_RESET 5'h00
`define SPBL_PU_LOW_MIN_US 50
`define SPBL_CLK_MHZ 200
`define SPBL_PU_LOW_CYC (`SPBL_PU_LOW_MIN_US * `SPBL_CLK_MHZ)
`define SPBL_RESP_OKAY 2'b00
`define SPBL_RESP_SLVERR 2'b10
`endif

// file: design/spbl_pkg.sv
// types for the strap pin boot latch
package spbl_pkg;
    typedef enum logic [1:0] {
        SPBL_BOOT_SPI,
        SPBL_BOOT_DOWNLOAD,
        SPBL_BOOT_UNDEF
    } spbl_boot_t;
    typedef enum {
        SPBL_ST_RESET,
        SPBL_ST_CAPTURE,
        SPBL_ST_HELD
    } spbl_state_t;
endpackage : spbl_pkg

// file: testbench/spbl_boot_latch_props.sv
// concurrent checks on the strap pin boot latch ports
`include "spbl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module spbl_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // pads and boot outputs
    input wire logic strap_pull_en,
    input wire logic [4:0] strap_pull_up,
    input wire logic strap_func_en,
    input wire logic boot_log_en,
    input wire logic boot_console_tx_silent,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_pdir; strap_pull_up == `SPBL_PULL_DEFAULT; endproperty
    a_pdir: assert property (p_pdir) else $error("pull direction wrong");
    property p_func; strap_func_en |-> !strap_pull_en; endproperty
    a_func: assert property (p_func) else $error("pull on in function mode");
    property p_silent; boot_console_tx_silent != boot_log_en; endproperty
    a_silent: assert property (p_silent) else $error("silent not inverse of log");
    property p_hold; strap_func_en [*4] |-> $stable(boot_log_en); endproperty
    a_hold: assert property (p_hold) else $error("held strap changed");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    a_bans: assert property (p_bans) else $error("no write response");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("no read response");
endmodule : spbl_chk
bind spbl_boot_latch spbl_chk spbl_chk_inst (.ref_clk, .rst, .strap_pull_en, .strap_pull_up,
    .strap_func_en, .boot_log_en, .boot_console_tx_silent, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// file: testbench/spbl_strap_drv.sv
// external strap driver with weak pull resolution
`timescale 1ns/1ps
`default_nettype none
module spbl_strap_drv (
    // control
    input wire logic ref_clk,
    input wire logic drive_en,
    input wire logic [4:0] drive_val,
    // pad state from the device
    input wire logic strap_pull_en,
    input wire logic [4:0] strap_pull_up,
    // strap pins
    output logic [4:0] straps
);
    logic [4:0] churn_r = 5'h15;
    always_ff @(posedge ref_clk) churn_r <= ~churn_r;
    // undriven pins settle to the weak pull, otherwise wander
    assign straps = drive_en ? drive_val : (strap_pull_en ? strap_pull_up : churn_r);
endmodule : spbl_strap_drv
`default_nettype wire

// file: testbench/tb_strap_pin_boot_latch.sv
// self-checking bench for the strap pin boot latch
`include "spbl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_strap_pin_boot_latch;
    logic ref_clk = 0, rst = 1, drive_en = 0;
    logic por_rst_in = 0, rtc_wdt_rst_in = 0, brownout_rst_in = 0, power_up_enable_input = 1;
    logic [4:0] drive_val = 0, straps, strap_pull_up;
    logic strap_pull_en, strap_func_en, flash_ldo_1v8, boot_download, boot_log_en;
    logic sdio_sample_rise, sdio_output_rise, boot_console_tx_silent;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_mismatch = 0, tests_run = 0;
    always #2.5 ref_clk = ~ref_clk;
    spbl_boot_latch spbl_boot_latch_inst (.ref_clk, .rst, .por_rst_in, .rtc_wdt_rst_in,
        .brownout_rst_in, .power_up_enable_input, .ldo_voltage_strap(straps[0]),
        .boot_select_strap(straps[1]), .download_qualifier_strap(straps[2]),
        .log_and_timing_strap(straps[3]), .sdio_edge_strap(straps[4]), .strap_pull_en,
        .strap_pull_up, .strap_func_en, .flash_ldo_1v8, .boot_download, .boot_log_en,
        .sdio_sample_rise, .sdio_output_rise, .boot_console_tx_silent, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    spbl_strap_drv spbl_strap_drv_inst (.ref_clk, .drive_en, .drive_val, .strap_pull_en,
        .strap_pull_up, .straps);
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
        if (what == "timeout") wrap_up();
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (i == 64) chk("timeout", 0, 1);
        chk("bresp", `SPBL_RESP_OKAY, s_axi_bresp);
    endtask : wr
    task automatic rd(input string what, input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] r);
        int i;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (i == 64) chk("timeout", 0, 1);
        chk(what, d, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
    endtask : rd
    task automatic boot(input int src, input logic [4:0] v, input logic drv);
        @(posedge ref_clk);
        drive_en <= drv;
        drive_val <= v;
        por_rst_in <= (src == 0);
        rtc_wdt_rst_in <= (src == 1);
        brownout_rst_in <= (src == 2);
        power_up_enable_input <= (src != 3);
        repeat (src == 3 ? `SPBL_PU_LOW_CYC : 8) @(posedge ref_clk);
        {por_rst_in, rtc_wdt_rst_in, brownout_rst_in, power_up_enable_input} <= 4'h1;
        repeat (10) @(posedge ref_clk);
        drive_en <= 1'b1;
        drive_val <= ~v;
        repeat (4) @(posedge ref_clk);
    endtask : boot
    initial begin
        int k;
        logic [4:0] v, o, s;
        logic [5:0] e;
        void'($urandom(74));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (k = 0; k < 8; k++) begin
            v = 5'($urandom());
            o = 5'($urandom());
            boot(k % 4, v, k != 1);
            // floating pins latch the weak pull levels
            s = (k != 1) ? v : `SPBL_PULL_DEFAULT;
            rd("strap", `SPBL_ADDR_STRAP, {27'h0, s}, `SPBL_RESP_OKAY);
            wr(`SPBL_ADDR_STRAP, {27'h0, ~s});
            rd("strap ro", `SPBL_ADDR_STRAP, {27'h0, s}, `SPBL_RESP_OKAY);
            wr(`SPBL_ADDR_OVR_CTRL, {27'h0, o});
            e = {~s[3], o[2] ? o[4] : s[4], o[2] ? o[3] : s[3], s[3], ~s[1] & ~s[2],
                o[0] ? o[1] : s[0]};
            rd("effect", `SPBL_ADDR_EFFECT, {26'h0, e}, `SPBL_RESP_OKAY);
            chk("ports", {26'h0, e}, {26'h0, boot_console_tx_silent, sdio_output_rise,
                sdio_sample_rise, boot_log_en, boot_download, flash_ldo_1v8});
            chk("func", 32'h1, {31'h0, strap_func_en});
            rd("sys stat", `SPBL_ADDR_SYS_STAT, 32'h5, `SPBL_RESP_OKAY);
            wr(`SPBL_ADDR_OVR_CTRL, 32'h0);
        end
        rd("unmapped", 4'h2, 32'h0, `SPBL_RESP_SLVERR);
        wrap_up();
    end
endmodule : tb_strap_pin_boot_latch
`default_nettype wire
